// ===== hdl/gpcfg_bank.sv
// Behaviour
// - bit 0 high makes pin input
// - bit 1 high inverts the pin's sense
// - bit 7 high makes driver open-drain
// - pin 2.4 has no alternate function
// - bit 2 hands pin to its peripheral
// - pins 2.5/2.6 carry music serial rx/tx
// - pin 2.7 carries system-management interrupt
// - pins 3.0/3.1 carry fan speed sense
// - pin 3.2 fan drive, main reset zero
// - pin 3.3 fan drive, main reset zero
// - pin 3.4 infrared rx, standby reset 0x05
// - pin 3.5 infrared tx, always resets 0x04
// - pin 3.6 carries keyboard reset
// - other pin registers reset to 0x01 on standby
`timescale 1ns/1ps

module gpcfg_bank
(
  input  wire logic                  sys_clk,                // 250 MHz clock
  input  wire logic                  rst,                    // Hard reset, sync
  input  wire logic                  standby_power_on_reset, // Standby power reset
  input  wire logic                  main_power_on_reset,    // Main power reset
  input  wire gpcfg_pkg::gpcfg_bus_t bus,                    // Register requests
  output logic [7:0]                 rdata_q,                // Read data, next cycle
  input  wire logic [10:0]           pad_in,                 // Pin levels
  output gpcfg_pkg::gpcfg_pad_t      pad_q,                  // Pin drive
  input  wire logic                  music_serial_tx,        // Peripheral to 2.6
  input  wire logic                  sys_mgmt_irq_out_n,     // Peripheral to 2.7
  input  wire logic                  fan_drive_b,            // Peripheral to 3.2
  input  wire logic                  fan_drive_a,            // Peripheral to 3.3
  input  wire logic                  infrared_tx_b,          // Peripheral to 3.5
  input  wire logic                  keyboard_reset_out_n,   // Peripheral to 3.6
  output logic                       music_serial_rx,        // From pin 2.5
  output logic                       fan_speed_sense_b,      // From pin 3.0
  output logic                       fan_speed_sense_a,      // From pin 3.1
  output logic                       infrared_rx_b           // From pin 3.4
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [10:0][7:0] cfg_q;
  logic [10:0]      data_q;
  logic [10:0]      in_s1_q;
  logic [10:0]      in_s2_q;
  logic [10:0]      dir_in;
  logic [10:0]      pol;
  logic [10:0]      alt;
  logic [10:0]      odrain;
  logic [10:0]      in_lvl;
  logic [10:0]      src;
  logic [10:0]      lvl;
  gpcfg_pkg::gpcfg_pad_t pad_d;
  logic             main_rst;

  assign main_rst = rst | main_power_on_reset;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Standby reset outranks the others; main/hard reset only touches
  // the fan and infrared-tx pins, the rest live on standby power.
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < gpcfg_pkg::GPCFG_NPINS; i++)
    begin
      if (standby_power_on_reset)
      begin
        cfg_q[i] <= gpcfg_pkg::gpcfg_stby_rst(i);
      end
      else if (main_rst)
      begin
        if (i == gpcfg_pkg::GPCFG_IX_FANB || i == gpcfg_pkg::GPCFG_IX_FANA)
          cfg_q[i] <= gpcfg_pkg::GPCFG_RST_MAIN_FAN;
        else if (i == gpcfg_pkg::GPCFG_IX_IRTX)
          cfg_q[i] <= gpcfg_pkg::GPCFG_RST_ALL_IRTX;
      end
      else if (bus.wr && bus.addr == gpcfg_pkg::GPCFG_OFFS[i])
      begin
        cfg_q[i] <= bus.wdata & gpcfg_pkg::gpcfg_wmask(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Output data register
  // ----------------------------------------------------------------
  // Levels driven by pins in plain general-purpose mode
  always_ff @(posedge sys_clk)
  begin
    if (standby_power_on_reset || main_rst)
      data_q <= {3'h0, gpcfg_pkg::GPCFG_RST_DATA};
    else if (bus.wr && bus.addr == gpcfg_pkg::GPCFG_OFF_DATA_LO)
      data_q[7:0] <= bus.wdata;
    else if (bus.wr && bus.addr == gpcfg_pkg::GPCFG_OFF_DATA_HI)
      data_q[10:8] <= bus.wdata[2:0];
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage is read further on
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      in_s1_q <= 11'h000;
      in_s2_q <= 11'h000;
    end
    else
    begin
      in_s1_q <= pad_in;
      in_s2_q <= in_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Only bits 0, 1, 2 and 7 are looked at
  always_comb
  begin
    for (int i = 0; i < gpcfg_pkg::GPCFG_NPINS; i++)
    begin
      dir_in[i] = cfg_q[i][gpcfg_pkg::GPCFG_BIT_DIR];
      pol[i]    = cfg_q[i][gpcfg_pkg::GPCFG_BIT_POL];
      alt[i]    = cfg_q[i][gpcfg_pkg::GPCFG_BIT_ALT];
      odrain[i] = cfg_q[i][gpcfg_pkg::GPCFG_BIT_OTYPE];
    end
  end

  // logical sense of every pin input
  assign in_lvl = in_s2_q ^ pol;

  // ----------------------------------------------------------------
  // Output source selection
  // ----------------------------------------------------------------
  // Alternate pins take their level from the peripheral instead of
  // the data register; direction and driver type still apply.
  always_comb
  begin
    src = data_q;
    if (alt[gpcfg_pkg::GPCFG_IX_MTX])
      src[gpcfg_pkg::GPCFG_IX_MTX] = music_serial_tx;
    if (alt[gpcfg_pkg::GPCFG_IX_SMI])
      src[gpcfg_pkg::GPCFG_IX_SMI] = sys_mgmt_irq_out_n;
    if (alt[gpcfg_pkg::GPCFG_IX_FANB])
      src[gpcfg_pkg::GPCFG_IX_FANB] = fan_drive_b;
    if (alt[gpcfg_pkg::GPCFG_IX_FANA])
      src[gpcfg_pkg::GPCFG_IX_FANA] = fan_drive_a;
    if (alt[gpcfg_pkg::GPCFG_IX_IRTX])
      src[gpcfg_pkg::GPCFG_IX_IRTX] = infrared_tx_b;
    if (alt[gpcfg_pkg::GPCFG_IX_KBRST])
      src[gpcfg_pkg::GPCFG_IX_KBRST] = keyboard_reset_out_n;
  end

  assign lvl = src ^ pol;

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  // Open-drain only ever pulls low; a high level releases the pin
  always_comb
  begin
    pad_d = '0;
    for (int i = 0; i < gpcfg_pkg::GPCFG_NPINS; i++)
    begin
      if (dir_in[i])
      begin
        pad_d.out[i]  = 1'b0;
        pad_d.oe_n[i] = 1'b1;
      end
      else if (odrain[i])
      begin
        pad_d.out[i]  = 1'b0;
        pad_d.oe_n[i] = lvl[i];
      end
      else
      begin
        pad_d.out[i]  = lvl[i];
        pad_d.oe_n[i] = 1'b0;
      end
    end
  end

  // Registered pads, released while in hard or standby reset
  always_ff @(posedge sys_clk)
  begin
    if (rst || standby_power_on_reset)
    begin
      pad_q.out  <= 11'h000;
      pad_q.oe_n <= 11'h7ff;
    end
    else
      pad_q <= pad_d;
  end

  // ----------------------------------------------------------------
  // Peripheral inputs
  // ----------------------------------------------------------------
  // Deselected serial lines idle high, tachometers idle low, so the
  // peripheral sees no spurious edges while a pin is plain GPIO.
  always_ff @(posedge sys_clk)
  begin
    if (rst || standby_power_on_reset)
    begin
      music_serial_rx   <= 1'b1;
      fan_speed_sense_b <= 1'b0;
      fan_speed_sense_a <= 1'b0;
      infrared_rx_b     <= 1'b1;
    end
    else
    begin
      music_serial_rx   <= alt[gpcfg_pkg::GPCFG_IX_MRX] ?
                           in_lvl[gpcfg_pkg::GPCFG_IX_MRX] : 1'b1;
      // fan speed sense b and a
      fan_speed_sense_b <= alt[gpcfg_pkg::GPCFG_IX_TACHB] &
                           in_lvl[gpcfg_pkg::GPCFG_IX_TACHB];
      fan_speed_sense_a <= alt[gpcfg_pkg::GPCFG_IX_TACHA] &
                           in_lvl[gpcfg_pkg::GPCFG_IX_TACHA];
      infrared_rx_b     <= alt[gpcfg_pkg::GPCFG_IX_IRRX] ?
                           in_lvl[gpcfg_pkg::GPCFG_IX_IRRX] : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses and idle cycles read zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else
    begin
      rdata_q <= 8'h00;
      if (bus.rd)
      begin
        for (int i = 0; i < gpcfg_pkg::GPCFG_NPINS; i++)
        begin
          if (bus.addr == gpcfg_pkg::GPCFG_OFFS[i])
            rdata_q <= cfg_q[i];
        end
        if (bus.addr == gpcfg_pkg::GPCFG_OFF_DATA_LO)
          rdata_q <= in_lvl[7:0];
        else if (bus.addr == gpcfg_pkg::GPCFG_OFF_DATA_HI)
          rdata_q <= {5'h00, in_lvl[10:8]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_dir_input_release:
    assert property (!standby_power_on_reset && cfg_q[0][0] |=> pad_q.oe_n[0])
    else $error("input pin 2.4 is being driven");

  a_pol_plain_drive:
    assert property (!standby_power_on_reset && cfg_q[0][7:0] == 8'h02
                     |=> pad_q.out[0] == !$past(data_q[0]) && !pad_q.oe_n[0])
    else $error("inverted push-pull pin 2.4 has wrong level");

  a_odrain_no_high:
    assert property (!standby_power_on_reset && cfg_q[1][7] && !cfg_q[1][0]
                     |=> pad_q.out[1] == 1'b0 && pad_q.oe_n[1] == $past(lvl[1]))
    else $error("open-drain pin 2.5 drove wrongly");

  a_reserved_dropped:
    assert property (bus.wr && bus.addr == gpcfg_pkg::GPCFG_OFF_P25
                     && !standby_power_on_reset && !main_power_on_reset
                     |=> cfg_q[1] == ($past(bus.wdata) & 8'h87))
    else $error("pin 2.5 register stored reserved bits");

  a_plain_no_alt:
    assert property (cfg_q[0][2] == 1'b0 && cfg_q[0][6:3] == 4'h0)
    else $error("pin 2.4 holds an alternate select");

  a_alt_music_tx:
    assert property (!standby_power_on_reset && cfg_q[2][2] && cfg_q[2][7:0] == 8'h04
                     |=> pad_q.out[2] == $past(music_serial_tx) && !pad_q.oe_n[2])
    else $error("pin 2.6 not driven from music serial tx");

  a_music_rx_route:
    assert property (!standby_power_on_reset && cfg_q[1][2]
                     |=> music_serial_rx == ($past(in_s2_q[1]) ^ $past(cfg_q[1][1])))
    else $error("music serial rx not taken from pin 2.5");

  a_smi_route:
    assert property (!standby_power_on_reset && cfg_q[3][2] && !cfg_q[3][0]
                     && !cfg_q[3][7]
                     |=> pad_q.out[3] == ($past(sys_mgmt_irq_out_n) ^ $past(cfg_q[3][1])))
    else $error("pin 2.7 not driven from interrupt output");

  a_tach_route:
    assert property (!standby_power_on_reset && !cfg_q[5][2]
                     |=> fan_speed_sense_a == 1'b0)
    else $error("fan speed sense a active while pin 3.1 is plain");

  a_fan_b_reset:
    assert property (main_power_on_reset && !standby_power_on_reset
                     |=> cfg_q[6] == 8'h00)
    else $error("pin 3.2 register not cleared on main reset");

  a_fan_a_standby:
    assert property (standby_power_on_reset |=> cfg_q[7] == 8'h01 ##1 cfg_q[7] == 8'h01
                     || $past(bus.wr))
    else $error("pin 3.3 register wrong after standby reset");

  a_irrx_standby:
    assert property (standby_power_on_reset |=> cfg_q[8] == 8'h05)
    else $error("pin 3.4 register not 0x05 after standby reset");

  a_irtx_hard:
    assert property ($fell(rst) |-> cfg_q[9] == 8'h04)
    else $error("pin 3.5 register not 0x04 after hard reset");

  a_kbrst_route:
    assert property (!standby_power_on_reset && cfg_q[10][7:0] == 8'h04
                     |=> pad_q.out[10] == $past(keyboard_reset_out_n))
    else $error("pin 3.6 not driven from keyboard reset");

  a_gpio_standby:
    assert property (standby_power_on_reset |=> cfg_q[0] == 8'h01 && cfg_q[3] == 8'h01)
    else $error("plain pin register not 0x01 after standby reset");

  a_read_masked:
    assert property (bus.rd && bus.addr == gpcfg_pkg::GPCFG_OFF_P26
                     |=> rdata_q[6:3] == 4'h0 && rdata_q == $past(cfg_q[2]))
    else $error("pin 2.6 read returned reserved bits");

  c_alt_select:
    cover property (bus.wr && bus.addr == gpcfg_pkg::GPCFG_OFF_P25 ##1 cfg_q[1][2]);

  c_odrain_low:
    cover property (cfg_q[1][7] && !cfg_q[1][0] ##1 !pad_q.oe_n[1]);

  c_standby_then_write:
    cover property (standby_power_on_reset ##1 bus.wr ##1 bus.rd);

  c_data_read:
    cover property (bus.rd && bus.addr == gpcfg_pkg::GPCFG_OFF_DATA_LO);

endmodule : gpcfg_bank

// ===== hdl/gpcfg_pkg.sv
package gpcfg_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int GPCFG_NPINS = 11;
  localparam int GPCFG_AW    = 8;
  localparam int GPCFG_DW    = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GPCFG_OFF_P24     = 8'h2f;
  localparam logic [7:0] GPCFG_OFF_P25     = 8'h30;
  localparam logic [7:0] GPCFG_OFF_P26     = 8'h31;
  localparam logic [7:0] GPCFG_OFF_P27     = 8'h32;
  localparam logic [7:0] GPCFG_OFF_P30     = 8'h33;
  localparam logic [7:0] GPCFG_OFF_P31     = 8'h34;
  localparam logic [7:0] GPCFG_OFF_P32     = 8'h35;
  localparam logic [7:0] GPCFG_OFF_P33     = 8'h36;
  localparam logic [7:0] GPCFG_OFF_P34     = 8'h37;
  localparam logic [7:0] GPCFG_OFF_P35     = 8'h38;
  localparam logic [7:0] GPCFG_OFF_P36     = 8'h39;
  localparam logic [7:0] GPCFG_OFF_DATA_LO = 8'h80;
  localparam logic [7:0] GPCFG_OFF_DATA_HI = 8'h81;

  // Offset of each pin's register, pin index 0 (2.4) rightmost
  localparam logic [10:0][7:0] GPCFG_OFFS = {
    GPCFG_OFF_P36, GPCFG_OFF_P35, GPCFG_OFF_P34, GPCFG_OFF_P33,
    GPCFG_OFF_P32, GPCFG_OFF_P31, GPCFG_OFF_P30, GPCFG_OFF_P27,
    GPCFG_OFF_P26, GPCFG_OFF_P25, GPCFG_OFF_P24};

  // ----------------------------------------------------------------
  // Field positions and write masks
  // ----------------------------------------------------------------
  localparam int         GPCFG_BIT_DIR     = 0;
  localparam int         GPCFG_BIT_POL     = 1;
  localparam int         GPCFG_BIT_ALT     = 2;
  localparam int         GPCFG_BIT_OTYPE   = 7;
  localparam logic [7:0] GPCFG_WMASK_ALT   = 8'h87;
  localparam logic [7:0] GPCFG_WMASK_PLAIN = 8'h83;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPCFG_RST_STBY_GPIO = 8'h01;
  localparam logic [7:0] GPCFG_RST_STBY_IRRX = 8'h05;
  localparam logic [7:0] GPCFG_RST_ALL_IRTX  = 8'h04;
  localparam logic [7:0] GPCFG_RST_MAIN_FAN  = 8'h00;
  localparam logic [7:0] GPCFG_RST_DATA      = 8'h00;

  // ----------------------------------------------------------------
  // Pin indices of the alternate functions
  // ----------------------------------------------------------------
  localparam int GPCFG_IX_PLAIN = 0;
  localparam int GPCFG_IX_MRX   = 1;
  localparam int GPCFG_IX_MTX   = 2;
  localparam int GPCFG_IX_SMI   = 3;
  localparam int GPCFG_IX_TACHB = 4;
  localparam int GPCFG_IX_TACHA = 5;
  localparam int GPCFG_IX_FANB  = 6;
  localparam int GPCFG_IX_FANA  = 7;
  localparam int GPCFG_IX_IRRX  = 8;
  localparam int GPCFG_IX_IRTX  = 9;
  localparam int GPCFG_IX_KBRST = 10;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpcfg_bus_t;

  typedef struct packed {
    logic [10:0] out;
    logic [10:0] oe_n;
  } gpcfg_pad_t;

  // Writable bits of a pin's register
  function automatic logic [7:0] gpcfg_wmask(input int idx);
    return (idx == GPCFG_IX_PLAIN) ? GPCFG_WMASK_PLAIN : GPCFG_WMASK_ALT;
  endfunction : gpcfg_wmask

  // Value taken on standby-power reset
  function automatic logic [7:0] gpcfg_stby_rst(input int idx);
    if (idx == GPCFG_IX_IRRX)
      return GPCFG_RST_STBY_IRRX;
    else if (idx == GPCFG_IX_IRTX)
      return GPCFG_RST_ALL_IRTX;
    else
      return GPCFG_RST_STBY_GPIO;
  endfunction : gpcfg_stby_rst

endpackage : gpcfg_pkg

// ===== tb/gpcfg_pins.sv
`timescale 1ns/1ps

module gpcfg_pins
(
  input  wire gpcfg_pkg::gpcfg_pad_t pad_q,   // Drive from the bank
  input  wire logic [10:0]           ext_en,  // Far side drives the pin
  input  wire logic [10:0]           ext_val, // Far side level
  output logic [10:0]                pad_in   // Resolved pin level
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // open-drain release pulled
  // Board pull-up: a released pin reads high unless the far side drives it, never the last level
  always_comb
  begin
    for (int i = 0; i < 11; i++)
    begin
      if (!pad_q.oe_n[i])
        pad_in[i] = pad_q.out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else
        pad_in[i] = 1'b1;
    end
  end
endmodule : gpcfg_pins

// ===== tb/gpcfg_bank_test.sv
`timescale 1ns/1ps

module gpcfg_bank_test;
  logic                  sys_clk;
  logic                  rst;
  logic                  stby_rst;
  logic                  main_rst;
  gpcfg_pkg::gpcfg_bus_t bus;
  logic [7:0]            rdata_q;
  logic [10:0]           pad_in;
  logic [10:0]           ext_en;
  logic [10:0]           ext_val;
  gpcfg_pkg::gpcfg_pad_t pad_q;
  logic [5:0]            per;
  logic [3:0]            alt_in;
  logic [7:0]            rv;
  int                    n_mismatch;
  int                    checked;
  int                    cyc;
  int                    oidx [6] = '{2, 3, 6, 7, 9, 10};
  int                    iidx [4] = '{1, 4, 5, 8};

  gpcfg_bank dut_u (.sys_clk(sys_clk), .rst(rst), .standby_power_on_reset(stby_rst),
    .main_power_on_reset(main_rst), .bus(bus), .rdata_q(rdata_q), .pad_in(pad_in),
    .pad_q(pad_q), .music_serial_tx(per[0]), .sys_mgmt_irq_out_n(per[1]),
    .fan_drive_b(per[2]), .fan_drive_a(per[3]), .infrared_tx_b(per[4]),
    .keyboard_reset_out_n(per[5]), .music_serial_rx(alt_in[0]),
    .fan_speed_sense_b(alt_in[1]), .fan_speed_sense_a(alt_in[2]),
    .infrared_rx_b(alt_in[3]));

  gpcfg_pins pins_u (.pad_q(pad_q), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // Clock, 4 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Whole run needs about 350 cycles; 5000 leaves margin
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  // Idle cycle after each strobe so no signal is assigned twice a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 d = rdata_q;
    @(posedge sys_clk);
  endtask : rd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // Samples a pin after the edge settles, then realigns to the edge
  task automatic chk_pin(input int i, input logic o, input logic oen);
    #1;
    chk1(pad_q.out[i], o);
    chk1(pad_q.oe_n[i], oen);
    @(posedge sys_clk);
  endtask : chk_pin

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_stby_values();
    for (int i = 0; i < 11; i++)
    begin
      rd(gpcfg_pkg::GPCFG_OFFS[i], rv);
      chk8(rv, (i == 8) ? 8'h05 : (i == 9) ? 8'h04 : 8'h01);
    end
    $display("test stby_values done");
  endtask : t_stby_values

  // Main-power or hard reset clears only the fan registers and sets infrared tx to 0x04
  task automatic t_main_reset(input bit hard);
    for (int i = 0; i < 11; i++)
      wr(gpcfg_pkg::GPCFG_OFFS[i], 8'h83);
    if (hard)
      rst <= 1'b1;
    else
      main_rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    main_rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 11; i++)
    begin
      rd(gpcfg_pkg::GPCFG_OFFS[i], rv);
      chk8(rv, (i == 6 || i == 7) ? 8'h00 : (i == 9) ? 8'h04 : 8'h83);
    end
    $display("test main_reset done");
  endtask : t_main_reset

  task automatic t_reserved();
    for (int i = 0; i < 11; i++)
    begin
      wr(gpcfg_pkg::GPCFG_OFFS[i], 8'hff);
      rd(gpcfg_pkg::GPCFG_OFFS[i], rv);
      chk8(rv, (i == 0) ? 8'h83 : 8'h87);
    end
    wr(8'h2e, 8'hff);
    rd(8'h2e, rv);
    chk8(rv, 8'h00);
    $display("test reserved done");
  endtask : t_reserved

  // Plain pin 2.4 through the data register
  task automatic t_plain_pin();
    wr(8'h2f, 8'h00);
    wr(8'h80, 8'h01);
    chk_pin(0, 1'b1, 1'b0);
    wr(8'h2f, 8'h02);
    chk_pin(0, 1'b0, 1'b0);
    wr(8'h2f, 8'h7c);
    chk_pin(0, 1'b1, 1'b0);
    wr(8'h2f, 8'h80);
    chk_pin(0, 1'b0, 1'b1);
    wr(8'h80, 8'h00);
    chk_pin(0, 1'b0, 1'b0);
    wr(8'h2f, 8'h01);
    chk_pin(0, 1'b0, 1'b1);
    // Pulled low against the board pull-up, so a stuck read shows
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h80, rv);
    chk1(rv[0], 1'b0);
    wr(8'h2f, 8'h03);
    rd(8'h80, rv);
    chk1(rv[0], 1'b1);
    $display("test plain_pin done");
  endtask : t_plain_pin

  // Each peripheral output wins over the data register once selected
  task automatic t_alt_out();
    wr(8'h80, 8'hff);
    wr(8'h81, 8'h07);
    wr(gpcfg_pkg::GPCFG_OFF_P25, 8'h80);
    chk_pin(1, 1'b0, 1'b1);
    wr(8'h80, 8'hfd);
    chk_pin(1, 1'b0, 1'b0);
    wr(8'h80, 8'hff);
    wr(gpcfg_pkg::GPCFG_OFF_P25, 8'h01);
    for (int k = 0; k < 6; k++)
    begin
      wr(gpcfg_pkg::GPCFG_OFFS[oidx[k]], 8'h04);
      per[k] <= 1'b1;
      @(posedge sys_clk);
      chk_pin(oidx[k], 1'b1, 1'b0);
      per[k] <= 1'b0;
      @(posedge sys_clk);
      chk_pin(oidx[k], 1'b0, 1'b0);
      wr(gpcfg_pkg::GPCFG_OFFS[oidx[k]], 8'h01);
    end
    $display("test alt_out done");
  endtask : t_alt_out

  // Deselected inputs idle (rx 1, tach 0); selected ones follow the pin
  task automatic t_alt_in();
    logic idle;
    for (int k = 0; k < 4; k++)
    begin
      idle = (k == 0 || k == 3);
      wr(gpcfg_pkg::GPCFG_OFFS[iidx[k]], 8'h01);
      ext_en[iidx[k]] <= 1'b1;
      ext_val[iidx[k]] <= ~idle;
      repeat (4) @(posedge sys_clk);
      #1 chk1(alt_in[k], idle);
      @(posedge sys_clk);
      wr(gpcfg_pkg::GPCFG_OFFS[iidx[k]], 8'h05);
      repeat (4) @(posedge sys_clk);
      #1 chk1(alt_in[k], ~idle);
      @(posedge sys_clk);
    end
    $display("test alt_in done");
  endtask : t_alt_in

  // Standby reset alone in mid-run: a driven pin is released and every
  // register returns to its standby value without any hard reset
  task automatic t_stby_mid();
    wr(8'h2f, 8'h00);
    chk_pin(0, 1'b1, 1'b0);
    stby_rst <= 1'b1;
    @(posedge sys_clk);
    stby_rst <= 1'b0;
    chk_pin(0, 1'b0, 1'b1);
    t_stby_values();
    $display("test stby_mid done");
  endtask : t_stby_mid

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Main sequence: both resets for 12 cycles, then the scenarios
  initial
  begin
    rst = 1'b1;
    stby_rst = 1'b1;
    main_rst = 1'b0;
    bus = '0;
    ext_en = 11'h000;
    ext_val = 11'h000;
    per = 6'h00;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    stby_rst <= 1'b0;
    @(posedge sys_clk);
    t_stby_values();
    t_main_reset(1'b0);
    t_main_reset(1'b1);
    t_reserved();
    t_plain_pin();
    t_alt_out();
    t_alt_in();
    t_stby_mid();
    close_out();
  end
endmodule : gpcfg_bank_test
